// *** hw/wgt_feature_regs.sv ***
// Purpose: Temperature register and Wiegand sensor test sequencer.
// Assumes: Register strobes arrive on clk_i from the serial frame layer.
// Notes: Pulse and temperature inputs come from another domain.
`timescale 1ns/10ps
module wgt_feature_regs
    import wgt_pkg::*;
#(
    parameter int MIN_REVS = WGT_MIN_REVS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sense_clk_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] temperature_sensor_port_i,
    input wire logic wiegand_pulse_i,
    input wire logic [7:0] wiegand_height_i,
    input wire logic [7:0] stored_avg_cw_i,
    input wire logic [7:0] stored_mrg_cw_i,
    input wire logic [7:0] stored_avg_ccw_i,
    input wire logic [7:0] stored_mrg_ccw_i,
    input wire logic store_busy_i,
    input wire logic store_fail_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic store_req_o,
    output logic [7:0] store_avg_cw_o,
    output logic [7:0] store_mrg_cw_o,
    output logic [7:0] store_avg_ccw_o,
    output logic [7:0] store_mrg_ccw_o,
    output logic test_active_o
);
    // Sensor-side (sense clock) registers; temp_prev here is clocked on clk_i.
    logic [7:0] sense_temp;
    logic [7:0] sense_height;
    logic sense_toggle;
    logic sense_pulse_d;
    logic sense_rst_meta;
    logic sense_rst_n;
    logic [7:0] temp_prev;
    // Core-side synchronisers and state.
    logic [2:0] tog_sync;
    logic [7:0] temp_meta;
    logic [7:0] temp_sync;
    logic [7:0] height_hold;
    logic busy_meta;
    logic busy_sync;
    logic fail_meta;
    logic fail_sync;
    logic [7:0] temperature;
    logic [7:0] bank_sel;
    logic [7:0] mode_sel;
    logic [7:0] unlock_key;
    logic [7:0] status;
    logic [7:0] next_status;
    wgt_state_type state;
    wgt_state_type next_state;
    logic pulse_evt;
    logic stats_start;
    logic cw_done;
    logic ccw_done;
    logic [7:0] cw_avg;
    logic [7:0] cw_mrg;
    logic [7:0] ccw_avg;
    logic [7:0] ccw_mrg;
    logic [7:0] rd_mux;
    logic [7:0] banked_rd;
    logic [7:0] direct_rd;

    // Address decode.
    wire is_direct = reg_addr_i[WGT_DIRECT_BIT];
    wire bank0 = !is_direct && (bank_sel == WGT_BANK_TEST);
    wire wr_bank = reg_wr_i && reg_addr_i == WGT_ADDR_BANK_SEL;
    wire wr_key = reg_wr_i && reg_addr_i == WGT_ADDR_KEY;
    wire unlocked = unlock_key == WGT_UNLOCK_KEY;
    wire wr_mode = reg_wr_i && reg_addr_i == WGT_ADDR_MODE && unlocked;
    wire test_mode = mode_sel == WGT_MODE_WIEGAND;
    wire wr_cmd = reg_wr_i && bank0 && reg_addr_i == WGT_ADDR_CMD &&
        test_mode;
    wire cmd_cw = wr_cmd && reg_wdata_i == WGT_CMD_START_CW;
    wire cmd_ccw = wr_cmd && reg_wdata_i == WGT_CMD_START_CCW;
    wire cmd_fin = wr_cmd && reg_wdata_i == WGT_CMD_FINISH;
    wire cmd_save = wr_cmd && reg_wdata_i == WGT_CMD_SAVE;

    // Reset brought into the sensor domain through two flip-flops.
    always_ff @(posedge sense_clk_i) begin
        sense_rst_meta <= rst_n_i;
        sense_rst_n <= sense_rst_meta;
    end

    // Sensor side: capture temperature and flag each pulse by a toggle.
    // The toggle needs a known start, or every crossing would be unknown.
    always_ff @(posedge sense_clk_i) begin
        sense_temp <= temperature_sensor_port_i;
        if (!sense_rst_n) begin
            sense_pulse_d <= 1'b0;
            sense_toggle <= 1'b0;
            sense_height <= WGT_RST_REG;
        end else begin
            sense_pulse_d <= wiegand_pulse_i;
            if (wiegand_pulse_i && !sense_pulse_d) begin
                sense_toggle <= !sense_toggle;
                sense_height <= wiegand_height_i;
            end
        end
    end

    // Toggle, level and word synchronisers into clk_i.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tog_sync <= 3'b000;
            temp_meta <= WGT_RST_REG;
            temp_sync <= WGT_RST_REG;
            busy_meta <= 1'b0;
            busy_sync <= 1'b0;
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
        end else begin
            tog_sync <= {tog_sync[1:0], sense_toggle};
            temp_meta <= sense_temp;
            temp_sync <= temp_meta;
            busy_meta <= store_busy_i;
            busy_sync <= busy_meta;
            fail_meta <= store_fail_i;
            fail_sync <= fail_meta;
        end
    end

    // Height is stable once the toggle edge has crossed; the event is
    // delayed one cycle so the statistics see the new height with it.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            height_hold <= WGT_RST_REG;
            pulse_evt <= 1'b0;
        end else begin
            pulse_evt <= tog_sync[2] ^ tog_sync[1];
            if (tog_sync[2] ^ tog_sync[1]) height_hold <= sense_height;
        end
    end

    // Temperature sample kept only when two synced readings agree.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            temp_prev <= WGT_RST_REG;
            temperature <= WGT_RST_REG;
        end else begin
            temp_prev <= temp_sync;
            if (temp_prev == temp_sync) temperature <= temp_sync;
        end
    end

    // Bank, key and mode registers.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bank_sel <= WGT_RST_REG;
            mode_sel <= WGT_MODE_OPERATION;
            unlock_key <= WGT_RST_REG;
        end else begin
            if (wr_bank) bank_sel <= reg_wdata_i;
            if (wr_key) unlock_key <= reg_wdata_i;
            if (wr_mode) mode_sel <= reg_wdata_i;
        end
    end

    // Per-direction statistics engines share one pulse stream.
    assign stats_start = cmd_cw || cmd_ccw;
    wgt_pulse_stats #(.MIN_REVS(MIN_REVS)) u_cw_stats (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(cmd_cw),
        .run_i(state == WGT_S_CW),
        .pulse_i(pulse_evt),
        .height_i(height_hold),
        .done_o(cw_done),
        .average_o(cw_avg),
        .margin_o(cw_mrg)
    );
    wgt_pulse_stats #(.MIN_REVS(MIN_REVS)) u_ccw_stats (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(cmd_ccw),
        .run_i(state == WGT_S_CCW),
        .pulse_i(pulse_evt),
        .height_i(height_hold),
        .done_o(ccw_done),
        .average_o(ccw_avg),
        .margin_o(ccw_mrg)
    );

    // Sequencer; direction is taken from the command only.
    always_comb begin
        next_state = state;
        next_status = status;
        case (state)
            WGT_S_IDLE: begin
                if (cmd_cw) begin
                    next_state = WGT_S_CW;
                    next_status = WGT_ST_CW_RUN;
                end else if (cmd_ccw) begin
                    next_status = WGT_ST_WRONG_DIR;
                end
            end
            WGT_S_CW: begin
                if (cw_done) begin
                    next_state = WGT_S_WAIT;
                    next_status = WGT_ST_WAIT_REV;
                end
            end
            WGT_S_WAIT: begin
                if (cmd_ccw) begin
                    next_state = WGT_S_CCW;
                    next_status = WGT_ST_CCW_RUN;
                end else if (cmd_cw) begin
                    next_status = WGT_ST_WRONG_DIR;
                end
            end
            WGT_S_CCW: begin
                if (ccw_done) begin
                    next_state = WGT_S_DONE;
                    next_status = WGT_ST_DONE;
                end
            end
            WGT_S_DONE: begin
                if (fail_sync) begin
                    next_state = WGT_S_FAIL;
                    next_status = WGT_ST_FAILED;
                end
            end
            WGT_S_FAIL: begin
                next_status = WGT_ST_FAILED;
            end
            default: begin
                next_state = WGT_S_IDLE;
                next_status = WGT_ST_STOPPED;
            end
        endcase
        if (cmd_fin || !test_mode) begin
            next_state = WGT_S_IDLE;
            next_status = WGT_ST_STOPPED;
        end
    end

    // Sequencer registers; status powers up stopped.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= WGT_S_IDLE;
            status <= WGT_ST_STOPPED;
        end else begin
            state <= next_state;
            status <= next_status;
        end
    end

    // Save request with the freshly measured values.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            store_req_o <= 1'b0;
            store_avg_cw_o <= WGT_RST_REG;
            store_mrg_cw_o <= WGT_RST_REG;
            store_avg_ccw_o <= WGT_RST_REG;
            store_mrg_ccw_o <= WGT_RST_REG;
        end else begin
            store_req_o <= cmd_save && state == WGT_S_DONE && !busy_sync;
            if (cmd_save && state == WGT_S_DONE) begin
                store_avg_cw_o <= cw_avg;
                store_mrg_cw_o <= cw_mrg;
                store_avg_ccw_o <= ccw_avg;
                store_mrg_ccw_o <= ccw_mrg;
            end
        end
    end

    // Read decode; results come from storage as loaded at boot.
    assign banked_rd =
        (reg_addr_i == WGT_ADDR_STATUS) ? status :
        (reg_addr_i == WGT_ADDR_AVG_CW) ? stored_avg_cw_i :
        (reg_addr_i == WGT_ADDR_MRG_CW) ? stored_mrg_cw_i :
        (reg_addr_i == WGT_ADDR_AVG_CCW) ? stored_avg_ccw_i :
        (reg_addr_i == WGT_ADDR_MRG_CCW) ? stored_mrg_ccw_i : 8'h00;
    assign direct_rd =
        (reg_addr_i == WGT_ADDR_TEMP) ? temperature :
        (reg_addr_i == WGT_ADDR_BANK_SEL) ? bank_sel :
        (reg_addr_i == WGT_ADDR_MODE) ? mode_sel : 8'h00;
    assign rd_mux = is_direct ? direct_rd : (bank0 ? banked_rd : 8'h00);

    // Registered read answer, one cycle after the strobe.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= WGT_RST_REG;
            reg_rvalid_o <= 1'b0;
            test_active_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) reg_rdata_o <= rd_mux;
            test_active_o <= next_state == WGT_S_CW ||
                next_state == WGT_S_CCW;
        end
    end
endmodule : wgt_feature_regs

// *** hw/wgt_pkg.sv ***
// Purpose: Shared constants for the Wiegand test and temperature registers.
// Assumes: Seven-bit register addresses as carried by the serial link.
// Notes: Direct registers sit at 0x40 and above, bank 0 below 0x40.
package wgt_pkg;
    // Direct register addresses.
    localparam logic [6:0] WGT_ADDR_BANK_SEL = 7'h40;
    localparam logic [6:0] WGT_ADDR_TEMP = 7'h66;
    localparam logic [6:0] WGT_ADDR_MODE = 7'h6a;
    localparam logic [6:0] WGT_ADDR_KEY = 7'h6b;
    // Bank 0 register addresses.
    localparam logic [6:0] WGT_ADDR_CMD = 7'h06;
    localparam logic [6:0] WGT_ADDR_STATUS = 7'h07;
    localparam logic [6:0] WGT_ADDR_AVG_CW = 7'h09;
    localparam logic [6:0] WGT_ADDR_MRG_CW = 7'h0a;
    localparam logic [6:0] WGT_ADDR_AVG_CCW = 7'h0b;
    localparam logic [6:0] WGT_ADDR_MRG_CCW = 7'h0c;
    // Address bit that separates direct from banked registers.
    localparam int WGT_DIRECT_BIT = 6;
    // Key, bank and mode values.
    localparam logic [7:0] WGT_UNLOCK_KEY = 8'h2a;
    localparam logic [7:0] WGT_BANK_TEST = 8'h00;
    localparam logic [7:0] WGT_MODE_OPERATION = 8'h00;
    localparam logic [7:0] WGT_MODE_WIEGAND = 8'h02;
    // Command values.
    localparam logic [7:0] WGT_CMD_START_CW = 8'h01;
    localparam logic [7:0] WGT_CMD_START_CCW = 8'h02;
    localparam logic [7:0] WGT_CMD_FINISH = 8'h03;
    localparam logic [7:0] WGT_CMD_SAVE = 8'h05;
    // Status values.
    localparam logic [7:0] WGT_ST_STOPPED = 8'h00;
    localparam logic [7:0] WGT_ST_CW_RUN = 8'h01;
    localparam logic [7:0] WGT_ST_WAIT_REV = 8'h03;
    localparam logic [7:0] WGT_ST_CCW_RUN = 8'h04;
    localparam logic [7:0] WGT_ST_DONE = 8'h06;
    localparam logic [7:0] WGT_ST_FAILED = 8'h07;
    localparam logic [7:0] WGT_ST_WRONG_DIR = 8'h30;
    // Reset values.
    localparam logic [7:0] WGT_RST_REG = 8'h00;
    // Revolutions per phase and temperature offset.
    localparam int WGT_MIN_REVS = 515;
    localparam logic [7:0] WGT_TEMP_OFFSET = 8'h32;
    // Result scale: tenths of a volt per count.
    localparam int WGT_RESULT_SCALE = 10;
    // Sequencer states.
    typedef enum logic [5:0] {
        WGT_S_IDLE = 6'b000001,
        WGT_S_CW = 6'b000010,
        WGT_S_WAIT = 6'b000100,
        WGT_S_CCW = 6'b001000,
        WGT_S_DONE = 6'b010000,
        WGT_S_FAIL = 6'b100000
    } wgt_state_type;
endpackage : wgt_pkg

// *** hw/wgt_pulse_stats.sv ***
// Purpose: Accumulates Wiegand pulse heights over one direction phase.
// Assumes: Pulse strobes are on clk_i and already synchronised.
// Notes: Average and a margin estimate are produced when the phase ends.
`timescale 1ns/10ps
module wgt_pulse_stats
    import wgt_pkg::*;
#(
    parameter int MIN_REVS = WGT_MIN_REVS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic run_i,
    input wire logic pulse_i,
    input wire logic [7:0] height_i,
    output logic done_o,
    output logic [7:0] average_o,
    output logic [7:0] margin_o
);
    logic [9:0] count;
    logic [17:0] sum;
    logic [7:0] lowest;
    logic [7:0] highest;
    logic [7:0] mean;
    logic [7:0] spread;
    logic [9:0] spread4;
    logic last_pulse;

    // Mean, with twice max-minus-min standing in for four deviations.
    assign mean = 8'(sum / 18'(count));
    assign spread = highest - lowest;
    assign spread4 = {2'b00, spread} + {2'b00, spread};
    assign last_pulse = run_i && pulse_i && (count == 10'(MIN_REVS - 1));

    // Count one pulse per revolution and finish after the last one.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || start_i) begin
            count <= '0;
            sum <= '0;
            lowest <= 8'hff;
            highest <= 8'h00;
            done_o <= 1'b0;
        end else if (run_i && pulse_i && !done_o) begin
            count <= count + 10'h001;
            sum <= sum + {10'h000, height_i};
            if (height_i < lowest) lowest <= height_i;
            if (height_i > highest) highest <= height_i;
            done_o <= last_pulse;
        end
    end

    // Results latch when the phase completes; the margin is clamped at zero.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            average_o <= WGT_RST_REG;
            margin_o <= WGT_RST_REG;
        end else if (done_o && count != 10'h000) begin
            average_o <= mean;
            margin_o <= ({2'b00, mean} > spread4) ?
                8'(({2'b00, mean} - spread4)) : 8'h00;
        end
    end
endmodule : wgt_pulse_stats

// *** verif/wgt_feature_props.sv ***
// Purpose: Port-level checks for the feature register block.
// Assumes: Core-clock ports only; reset is synchronous, active low.
// Notes: Attached to every instance by the bind below.
`timescale 1ns/10ps
module wgt_feature_props
    import wgt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic store_req_o,
    input wire logic test_active_o
);
    // All checks use the core clock and pause while in reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // A write aimed at the test command register.
    wire logic cmd_wr = reg_wr_i && reg_addr_i == WGT_ADDR_CMD;

    a_read_answers: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe got no valid answer");
    a_no_stray_valid: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without a read");
    a_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_abort_stops: assert property
        (cmd_wr && reg_wdata_i == WGT_CMD_FINISH |=> !test_active_o)
        else $error("finish command left a phase running");
    a_start_cause: assert property
        ($rose(test_active_o) |-> $past(cmd_wr))
        else $error("phase started without a command write");
    a_save_cause: assert property ($rose(store_req_o) |->
        $past(cmd_wr) && $past(reg_wdata_i) == WGT_CMD_SAVE)
        else $error("save request without a save command");
    a_save_pulse: assert property (store_req_o |=> !store_req_o)
        else $error("save request longer than one cycle");
    a_idle_reset: assert property
        ($rose(rst_n_i) |-> !test_active_o && !store_req_o)
        else $error("block not idle after reset");

    // Main scenarios reached.
    c_phase: cover property ($rose(test_active_o));
    c_save: cover property (store_req_o);
    c_done: cover property (reg_rvalid_o && reg_rdata_o == WGT_ST_DONE);
endmodule : wgt_feature_props

bind wgt_feature_regs wgt_feature_props wgt_feature_props_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .store_req_o(store_req_o),
    .test_active_o(test_active_o));

// *** verif/wgt_feature_regs_bench.sv ***
// Purpose: Self-checking bench for the feature register block.
// Assumes: Short phases through MIN_REVS; stored results are fixed.
// Notes: Table rows are {write, address, data or expected read}.
`timescale 1ns/10ps
module wgt_feature_regs_bench
    import wgt_pkg::*;
;
    localparam int REVS = 4;
    logic clk_i = 1'b0;
    logic sense_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [6:0] reg_addr_i = 7'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic store_fail_i = 1'b0;
    logic turning = 1'b0;
    logic saw_req = 1'b0;
    logic pulse, busy, rvalid, store_req, active;
    logic [7:0] height, rdata, sa_cw, sm_cw, sa_ccw, sm_ccw;
    logic [31:0] saved;
    int miscompares = 0;
    int checked = 0;
    int revs = 0;
    int i;
    logic [15:0] rows [22] = '{16'h664b, 16'hea02, 16'h6a00, 16'h8601,
        16'h0700, 16'heb2a, 16'hea02, 16'h6a02, 16'hc000, 16'h4000,
        16'h664b, 16'h8602, 16'h0730, 16'h8601, 16'h0701, 16'h8603,
        16'h0700, 16'h093c, 16'h0a36, 16'h0b3d, 16'h0c37, 16'h2000};

    wgt_feature_regs #(.MIN_REVS(REVS)) wgt_feature_regs_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sense_clk_i(sense_clk_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .temperature_sensor_port_i(8'h4b),
        .wiegand_pulse_i(pulse), .wiegand_height_i(height),
        .stored_avg_cw_i(8'h3c), .stored_mrg_cw_i(8'h36),
        .stored_avg_ccw_i(8'h3d), .stored_mrg_ccw_i(8'h37),
        .store_busy_i(busy), .store_fail_i(store_fail_i),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .store_req_o(store_req),
        .store_avg_cw_o(sa_cw), .store_mrg_cw_o(sm_cw),
        .store_avg_ccw_o(sa_ccw), .store_mrg_ccw_o(sm_ccw),
        .test_active_o(active));

    wgt_motor_model wgt_motor_model_inst (.sense_clk_i(sense_clk_i),
        .turning_i(turning), .pulse_o(pulse), .height_o(height),
        .store_busy_o(busy));

    // Core clock and an unrelated sensor clock.
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #3;
        forever #15 sense_clk_i = ~sense_clk_i;
    end
    // Counts revolutions and catches the one-cycle save request.
    always @(posedge pulse) revs++;
    always @(posedge clk_i) begin
        if (store_req) begin
            saw_req <= 1'b1;
            saved <= {sa_cw, sm_cw, sa_ccw, sm_ccw};
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] q);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check("read valid", 32'h1, {31'h0, rvalid});
        q = rdata;
    endtask : rd

    task automatic wait_status(input logic [7:0] exp);
        logic [7:0] q;
        for (int n = 0; n < 300; n++) begin
            rd(WGT_ADDR_STATUS, q);
            if (q === exp) return;
        end
        check("status wait", exp, q);
        finish_test();
    endtask : wait_status

    // Main sequence: table rows, then a full run, then a mid-run reset.
    initial begin
        logic [7:0] q;
        int r0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        for (i = 0; i < 22; i++) begin
            if (rows[i][15]) begin
                wr(rows[i][14:8], rows[i][7:0]);
            end else begin
                rd(rows[i][14:8], q);
                check($sformatf("row %0d", i), rows[i][7:0], q);
            end
        end
        turning <= 1'b1;
        wr(WGT_ADDR_CMD, WGT_CMD_START_CW);
        r0 = revs;
        wait_status(WGT_ST_WAIT_REV);
        // A pulse already in flight at the start edge may be counted.
        check("cw revs", 32'h1, {31'h0, revs - r0 >= REVS - 1});
        wr(WGT_ADDR_CMD, WGT_CMD_START_CW);
        rd(WGT_ADDR_STATUS, q);
        check("wrong dir", WGT_ST_WRONG_DIR, q);
        wr(WGT_ADDR_CMD, WGT_CMD_START_CCW);
        r0 = revs;
        rd(WGT_ADDR_STATUS, q);
        check("ccw run", WGT_ST_CCW_RUN, q);
        check("phase active", 32'h1, {31'h0, active});
        wait_status(WGT_ST_DONE);
        check("ccw revs", 32'h1, {31'h0, revs - r0 >= REVS - 1});
        turning <= 1'b0;
        wr(WGT_ADDR_CMD, WGT_CMD_SAVE);
        for (i = 0; i < 8 && !saw_req; i++) @(posedge clk_i);
        check("save request", 32'h1, {31'h0, saw_req});
        check("save data", {4{8'h40}}, saved);
        check("margin pass", 32'h1, {31'h0, saved[23:16] > 8'h35});
        rd(WGT_ADDR_AVG_CW, q);
        check("boot copy", 8'h3c, q);
        store_fail_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(WGT_ADDR_STATUS, q);
        check("failed", WGT_ST_FAILED, q);
        store_fail_i <= 1'b0;
        wr(WGT_ADDR_CMD, WGT_CMD_FINISH);
        rd(WGT_ADDR_STATUS, q);
        check("finished", WGT_ST_STOPPED, q);
        wr(WGT_ADDR_MODE, WGT_MODE_OPERATION);
        wr(WGT_ADDR_MODE, WGT_MODE_WIEGAND);
        rd(WGT_ADDR_MODE, q);
        check("key kept", WGT_MODE_WIEGAND, q);
        wr(WGT_ADDR_CMD, WGT_CMD_START_CW);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(WGT_ADDR_STATUS, q);
        check("status after reset", WGT_ST_STOPPED, q);
        finish_test();
    end
endmodule : wgt_feature_regs_bench

// *** verif/wgt_motor_model.sv ***
// Purpose: Motor and sensor stand-in that makes Wiegand pulses.
// Assumes: One pulse per revolution on the sensor clock.
// Notes: Height lines carry garbage outside the pulse window.
`timescale 1ns/10ps
module wgt_motor_model (
    input wire logic sense_clk_i,
    input wire logic turning_i,
    output logic pulse_o,
    output logic [7:0] height_o,
    output logic store_busy_o
);
    logic [3:0] phase = 4'h0;
    // One revolution lasts sixteen sensor clocks and always completes.
    always @(posedge sense_clk_i) begin
        if (turning_i || phase != 4'h0) phase <= phase + 4'h1;
    end
    // The pulse is the same in either direction; nothing marks it.
    assign pulse_o = phase == 4'h8 || phase == 4'h9;
    assign height_o = (phase >= 4'h7 && phase <= 4'ha) ? 8'h40 : 8'hbf;
    // The store never reports busy in these runs.
    assign store_busy_o = 1'b0;
endmodule : wgt_motor_model
